// ---- eep_pkg.sv ----
// constants, field layouts and state codes for the two-wire eeprom pair
// assumes both ends and the bench import this package whole
// Functional notes
// - array of 512 bytes of 8 bits
// - serial clock up to 400 kHz
// - serial clock samples input and shifts output
// - data line pulled low only, pulled up
// - chip selects must match select bits b3 b2
// - selects tied; floating select reads as 0
// - five-pin variant treats both selects as 0
// - write protect high blocks all array writes
// - protected: select, address acked, data not
// - ignore bus until power-on threshold passed
// - threshold crossing resets to standby; master waits
// - below threshold at power-down stop responding
// - stop without write cycle enters standby
// - start is data fall with clock high
// - stop after write starts cycle, bus ignored
// - ack select on match, else deselect
// - select lsb 1 reads, 0 writes
package eep_pkg;
   localparam int MEM_DEPTH = 512;
   localparam int AW = 9;
   localparam int PAGE = 16;
   localparam logic [3:0] DEV_TYPE = 4'ha;
   // count of link clocks the internal write cycle lasts
   localparam int WR_CYC_DEF = 256;
   // sync reset: clock and data idle high, the rest low
   localparam logic [5:0] SYNC_RST = 6'h03;
   localparam int SCL_KHZ = 400;
   localparam int PCLK_KHZ = 100000;
   // quarter of the serial clock period, rounded up
   localparam int SCL_QTR = (PCLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ADDR = 8'h04;
   localparam logic [7:0] OFS_WDATA = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0c;
   localparam logic [7:0] OFS_RDATA = 8'h10;
   localparam int CTRL_GO = 0;
   localparam int CTRL_RD = 1;
   localparam int CTRL_CEL = 2;
   localparam int CTRL_CEH = 3;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_NACK = 2;
   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_DSEL = 3'b001,
      D_ADDR = 3'b010,
      D_WDAT = 3'b011,
      D_RDAT = 3'b100,
      D_BUSY = 3'b101
   } eep_dev_st_e;
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_START = 2'b01,
      H_BIT = 2'b10,
      H_STOP = 2'b11
   } eep_hst_st_e;
endpackage : eep_pkg

// ---- eep_if.sv ----
// two-wire link between the bus master and the eeprom
// assumes the bench drives the board straps ce_lo, ce_hi and wp
interface eep_if;
   logic scl;
   logic host_sda_oe;
   logic dev_sda_oe;
   logic sda;
   logic ce_lo;
   logic ce_hi;
   logic wp;
   assign sda = ~(host_sda_oe | dev_sda_oe);
   // straps are tied levels; bench drives 0 for an open pin
   modport host (output scl, output host_sda_oe, input sda);
   modport dev (input scl, input sda, input ce_lo, input ce_hi,
      input wp, output dev_sda_oe);
endinterface : eep_if

// ---- eep_dev.sv ----
// eeprom slave end: select decode, protect, page buffer, write cycle
// assumes link_clk oversamples the serial clock by a wide margin
//
// The address map and the APB slave port are this design's own decisions.
module eep_dev
   import eep_pkg::*;
#(
   parameter bit FIVE_PIN = 1'b0,
   parameter int WR_CYC = WR_CYC_DEF
) (
   input wire logic link_clk,
   input wire logic por_n,
   input wire logic vcc_ok,
   output logic standby,
   output logic wr_busy,
   eep_if.dev bus
);
   eep_dev_st_e st;
   logic [5:0] raw;
   logic [5:0] s1;
   logic [5:0] s2;
   logic scl_p;
   logic sda_p;
   logic [3:0] bitcnt;
   logic rose;
   logic [7:0] shreg;
   logic [7:0] txsh;
   logic sda_oe;
   logic drv_ack;
   logic mack;
   logic a8;
   logic [AW-1:0] addr;
   logic [PAGE-1:0] mask;
   logic [3:0] last_off;
   logic armed;
   logic [15:0] wcnt;
   logic [7:0] mem [0:MEM_DEPTH-1];
   logic [7:0] pbuf [0:PAGE-1];

   assign raw = {vcc_ok, bus.wp, bus.ce_hi, bus.ce_lo, bus.sda, bus.scl};
   assign bus.dev_sda_oe = sda_oe;

   wire scl_h = s2[0];
   wire sda_i = s2[1];
   // straps taken as plain levels, open pin low
   // five-pin variant reads selects as zero
   wire ce_lo_v = FIVE_PIN ? 1'b0 : s2[2];
   wire ce_hi_v = FIVE_PIN ? 1'b0 : s2[3];
   wire wp_v = s2[4];
   wire vcc_v = s2[5];
   // clock edges strobe data in and out
   wire scl_rise = scl_h & ~scl_p;
   wire scl_fall = ~scl_h & scl_p;
   // start is data falling under a high clock
   wire start_c = scl_h & scl_p & sda_p & ~sda_i;
   wire stop_c = scl_h & scl_p & ~sda_p & sda_i;
   wire bit_end = scl_fall & rose;
   // type code and both select bits must match
   wire dsel_hit = (shreg[7:4] == DEV_TYPE) & (shreg[3] == ce_hi_v) &
      (shreg[2] == ce_lo_v);
   // protected bytes never reach the page buffer
   wire pb_we = bit_end & (bitcnt == 4'h7) & (st == D_WDAT) & ~wp_v;
   wire wr_last = (wcnt == 16'(WR_CYC - 1));
   wire mem_we = (st == D_BUSY) & (wcnt < 16'(PAGE)) & mask[wcnt[3:0]];
   wire [AW-1:0] mem_wa = {addr[AW-1:4], wcnt[3:0]};
   wire [7:0] rd_byte = mem[addr];

   // two-stage sync, fast enough for 400 kHz
   always_ff @(posedge link_clk or negedge por_n) begin
      if (!por_n) begin
         s1 <= SYNC_RST;
         s2 <= SYNC_RST;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         s1 <= raw;
         s2 <= s1;
         scl_p <= s2[0];
         sda_p <= s2[1];
      end
   end

   // storage array and page buffer, no reset
   always_ff @(posedge link_clk) begin
      if (pb_we) begin
         pbuf[addr[3:0]] <= shreg;
      end
      if (mem_we) begin
         mem[mem_wa] <= pbuf[wcnt[3:0]];
      end
   end

   // held in reset until the threshold is passed
   always_ff @(posedge link_clk or negedge por_n) begin
      if (!por_n) begin
         st <= D_IDLE;
         bitcnt <= 4'h0;
         rose <= 1'b0;
         shreg <= 8'h00;
         txsh <= 8'h00;
         sda_oe <= 1'b0;
         drv_ack <= 1'b0;
         mack <= 1'b0;
         a8 <= 1'b0;
         addr <= 9'h000;
         mask <= 16'h0000;
         last_off <= 4'h0;
         armed <= 1'b0;
         wcnt <= 16'h0000;
         standby <= 1'b1;
         wr_busy <= 1'b0;
      end else begin
         standby <= (st == D_IDLE);
         wr_busy <= (st == D_BUSY);
         if (!vcc_v) begin
            // supply low: drop off the bus
            st <= D_IDLE;
            sda_oe <= 1'b0;
            drv_ack <= 1'b0;
            mask <= 16'h0000;
            armed <= 1'b0;
         end else if (st == D_BUSY) begin
            // write cycle: bus ignored, output off
            sda_oe <= 1'b0;
            wcnt <= wcnt + 16'h0001;
            if (wr_last) begin
               st <= D_IDLE;
               addr[3:0] <= last_off + 4'h1;
               mask <= 16'h0000;
            end
         end else if (start_c) begin
            st <= D_DSEL;
            bitcnt <= 4'h0;
            rose <= 1'b0;
            sda_oe <= 1'b0;
            drv_ack <= 1'b0;
            mask <= 16'h0000;
            armed <= 1'b0;
         end else if (stop_c) begin
            sda_oe <= 1'b0;
            drv_ack <= 1'b0;
            // stop in the tenth slot starts the write
            if (armed && (mask != 16'h0000)) begin
               st <= D_BUSY;
               wcnt <= 16'h0000;
            end else begin
               st <= D_IDLE;
            end
         end else if (st != D_IDLE) begin
            if (scl_rise) begin
               rose <= 1'b1;
               if (bitcnt < 4'h8) begin
                  shreg <= {shreg[6:0], sda_i};
               end else if (st == D_RDAT && !drv_ack) begin
                  mack <= ~sda_i;
               end
            end else if (bit_end) begin
               rose <= 1'b0;
               // stays armed through the tenth slot only
               armed <= 1'b0;
               if (bitcnt == 4'h7) begin
                  bitcnt <= 4'h8;
                  case (st)
                     D_DSEL: begin
                        if (dsel_hit) begin
                           sda_oe <= 1'b1;
                           drv_ack <= 1'b1;
                           mack <= 1'b1;
                           if (shreg[0]) begin
                              st <= D_RDAT;
                           end else begin
                              st <= D_ADDR;
                              a8 <= shreg[1];
                           end
                        end else begin
                           st <= D_IDLE;
                        end
                     end
                     D_ADDR: begin
                        sda_oe <= 1'b1;
                        drv_ack <= 1'b1;
                        addr <= {a8, shreg};
                        st <= D_WDAT;
                     end
                     D_WDAT: begin
                        // protect level read at each data byte
                        if (!wp_v) begin
                           sda_oe <= 1'b1;
                           drv_ack <= 1'b1;
                           mask[addr[3:0]] <= 1'b1;
                           last_off <= addr[3:0];
                           addr[3:0] <= addr[3:0] + 4'h1;
                        end
                     end
                     D_RDAT: begin
                        sda_oe <= 1'b0;
                     end
                     default: begin
                        st <= D_IDLE;
                     end
                  endcase
               end else if (bitcnt == 4'h8) begin
                  bitcnt <= 4'h0;
                  drv_ack <= 1'b0;
                  sda_oe <= 1'b0;
                  if (st == D_WDAT) begin
                     armed <= 1'b1;
                  end
                  if (st == D_RDAT) begin
                     if (mack) begin
                        txsh <= rd_byte;
                        sda_oe <= ~rd_byte[7];
                        addr <= addr + 9'h001;
                     end else begin
                        st <= D_IDLE;
                     end
                  end
               end else begin
                  bitcnt <= bitcnt + 4'h1;
                  if (st == D_RDAT) begin
                     txsh <= {txsh[6:0], 1'b0};
                     sda_oe <= ~txsh[6];
                  end
               end
            end
         end
      end
   end
endmodule : eep_dev

// ---- eep_host.sv ----
// bus master end: apb registers, serial clock divider, byte sequencer
// assumes one apb master; pclk is the only clock of this end
module eep_host
   import eep_pkg::*;
#(
   parameter int QTR = SCL_QTR
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   eep_if.host bus
);
   eep_hst_st_e st;
   logic rd;
   logic cel;
   logic ceh;
   logic [AW-1:0] addr;
   logic [7:0] wdat;
   logic [7:0] rdat;
   logic busy;
   logic done;
   logic nack;
   logic [7:0] qcnt;
   logic [1:0] q;
   logic [1:0] idx;
   logic [3:0] bitn;
   logic [7:0] txsh;
   logic [7:0] rxsh;
   logic scl;
   logic sda_oe;
   logic s1;
   logic sda_s;

   assign bus.scl = scl;
   assign bus.host_sda_oe = sda_oe;

   wire acc = psel & penable & ~pready;
   wire fin = psel & penable & pready;
   wire hit = (paddr == OFS_CTRL) | (paddr == OFS_ADDR) |
      (paddr == OFS_WDATA) | (paddr == OFS_STAT) | (paddr == OFS_RDATA);
   wire go = fin & pwrite & (paddr == OFS_CTRL) & pwdata[CTRL_GO] & ~busy;
   wire [31:0] rd_mux =
      (paddr == OFS_CTRL) ? {28'h0, ceh, cel, rd, 1'b0} :
      (paddr == OFS_ADDR) ? {23'h0, addr} :
      (paddr == OFS_WDATA) ? {24'h0, wdat} :
      (paddr == OFS_STAT) ? {29'h0, nack, done, busy} :
      (paddr == OFS_RDATA) ? {24'h0, rdat} : 32'h0;
   wire tick = (qcnt == 8'(QTR - 1));
   // lsb of the select byte: 1 read, 0 write
   wire [7:0] sel_w = {DEV_TYPE, ceh, cel, addr[8], 1'b0};
   wire [7:0] sel_r = {DEV_TYPE, ceh, cel, addr[8], 1'b1};
   wire [7:0] next_tx = (idx == 2'd0) ? sel_w :
      (idx == 2'd1) ? addr[7:0] : rd ? sel_r : wdat;
   // byte that follows the current one inside a frame
   wire [7:0] follow_tx = (idx == 2'd0) ? addr[7:0] : wdat;
   wire is_rx = rd & (idx == 2'd3);
   wire last_b = rd ? (idx == 2'd3) : (idx == 2'd2);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         rd <= 1'b0;
         cel <= 1'b0;
         ceh <= 1'b0;
         addr <= 9'h000;
         wdat <= 8'h00;
         s1 <= 1'b1;
         sda_s <= 1'b1;
      end else begin
         s1 <= bus.sda;
         sda_s <= s1;
         pready <= acc;
         pslverr <= acc & ~hit;
         prdata <= (acc & ~pwrite) ? rd_mux : 32'h0;
         if (fin & pwrite & ~busy) begin
            if (paddr == OFS_CTRL) begin
               rd <= pwdata[CTRL_RD];
               cel <= pwdata[CTRL_CEL];
               ceh <= pwdata[CTRL_CEH];
            end
            if (paddr == OFS_ADDR) begin
               addr <= pwdata[AW-1:0];
            end
            if (paddr == OFS_WDATA) begin
               wdat <= pwdata[7:0];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= H_IDLE;
         busy <= 1'b0;
         done <= 1'b0;
         nack <= 1'b0;
         rdat <= 8'h00;
         qcnt <= 8'h00;
         q <= 2'd0;
         idx <= 2'd0;
         bitn <= 4'h0;
         txsh <= 8'h00;
         rxsh <= 8'h00;
         scl <= 1'b1;
         sda_oe <= 1'b0;
      end else if (st == H_IDLE) begin
         scl <= 1'b1;
         sda_oe <= 1'b0;
         qcnt <= 8'h00;
         q <= 2'd0;
         if (go) begin
            st <= H_START;
            busy <= 1'b1;
            done <= 1'b0;
            nack <= 1'b0;
            idx <= 2'd0;
         end
      end else begin
         // quarter-period divider gives at most 400 kHz
         qcnt <= tick ? 8'h00 : qcnt + 8'h01;
         if (tick) begin
            q <= q + 2'd1;
            case (st)
               H_START: begin
                  // data falls while the clock is high
                  if (q == 2'd0) sda_oe <= 1'b0;
                  if (q == 2'd1) scl <= 1'b1;
                  if (q == 2'd2) sda_oe <= 1'b1;
                  if (q == 2'd3) begin
                     scl <= 1'b0;
                     st <= H_BIT;
                     bitn <= 4'h0;
                     txsh <= next_tx;
                  end
               end
               H_BIT: begin
                  // drive low only, release for ones
                  if (q == 2'd0) sda_oe <= (bitn < 4'h8) & ~is_rx & ~txsh[7];
                  if (q == 2'd1) scl <= 1'b1;
                  if (q == 2'd2) begin
                     if (bitn < 4'h8) begin
                        rxsh <= {rxsh[6:0], sda_s};
                     end else if (!is_rx && sda_s) begin
                        nack <= 1'b1;
                     end
                  end
                  if (q == 2'd3) begin
                     scl <= 1'b0;
                     txsh <= {txsh[6:0], 1'b0};
                     bitn <= bitn + 4'h1;
                     if (bitn == 4'h8) begin
                        bitn <= 4'h0;
                        idx <= idx + 2'd1;
                        txsh <= follow_tx;
                        if (is_rx) rdat <= rxsh;
                        if (nack || last_b) begin
                           st <= H_STOP;
                        end else if (rd && idx == 2'd1) begin
                           st <= H_START;
                        end
                     end
                  end
               end
               H_STOP: begin
                  // stop leaves the device in standby, or starts its write cycle after an armed write
                  if (q == 2'd0) sda_oe <= 1'b1;
                  if (q == 2'd1) scl <= 1'b1;
                  if (q == 2'd2) sda_oe <= 1'b0;
                  if (q == 2'd3) begin
                     st <= H_IDLE;
                     busy <= 1'b0;
                     done <= 1'b1;
                  end
               end
               default: st <= H_IDLE;
            endcase
         end
      end
   end
endmodule : eep_host

// ---- eep_link_chk.sv ----
// concurrent checks on the two-wire link between host and eeprom
// assumes the bench instantiates it beside the link interface
module eep_link_chk
   import eep_pkg::*;
#(
   parameter int QTR = SCL_QTR,
   parameter int WR_CYC = WR_CYC_DEF
) (
   input logic pclk,
   input logic presetn,
   input logic link_clk,
   input logic por_n,
   input logic vcc_ok,
   input logic standby,
   input logic wr_busy,
   input logic scl,
   input logic host_sda_oe,
   input logic dev_sda_oe,
   input logic wp
);
   localparam int START_HI = QTR + 2;
   localparam int CYC_LO = WR_CYC - 1;
   localparam int CYC_HI = WR_CYC + 1;
   int busy_cnt;

   // length of the current internal write cycle
   always_ff @(posedge link_clk or negedge por_n) begin
      if (!por_n) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= wr_busy ? busy_cnt + 1 : 0;
      end
   end

   chk_host_idle_rel : assert property ( // line released
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> scl && !host_sda_oe)
      else $error("host drives the link right after reset");
   chk_host_start : assert property ( // start framing
      @(posedge pclk) disable iff (!presetn)
      $rose(host_sda_oe) && scl |-> scl [*4] ##[1:START_HI] !scl)
      else $error("start not followed by clock low in time");
   chk_por_quiet : assert property ( // quiet at power-up
      @(posedge link_clk) disable iff (!por_n)
      $rose(por_n) |-> !dev_sda_oe [*3])
      else $error("device drives data right after power-on");
   chk_vcc_release : assert property ( // quiet below threshold
      @(posedge link_clk) disable iff (!por_n)
      !vcc_ok [*6] |-> !dev_sda_oe && !wr_busy)
      else $error("device active with supply low");
   chk_busy_quiet : assert property ( // bus ignored in cycle
      @(posedge link_clk) disable iff (!por_n)
      wr_busy |-> !dev_sda_oe)
      else $error("device drives data during write cycle");
   chk_idle_quiet : assert property ( // standby releases data
      @(posedge link_clk) disable iff (!por_n)
      standby && $past(standby) |-> !dev_sda_oe)
      else $error("device drives data in standby");
   chk_wp_no_cycle : assert property ( // no cycle when protected
      @(posedge link_clk) disable iff (!por_n)
      $rose(wr_busy) |-> !wp)
      else $error("write cycle started while protected");
   chk_dev_scl_low : assert property ( // output shifts on low clock
      @(posedge link_clk) disable iff (!por_n)
      $changed(dev_sda_oe) && vcc_ok |-> !scl)
      else $error("device changed data while clock high");
   chk_cycle_len : assert property ( // write cycle length
      @(posedge link_clk) disable iff (!por_n)
      $fell(wr_busy) && vcc_ok |-> busy_cnt >= CYC_LO && busy_cnt <= CYC_HI)
      else $error("write cycle length wrong");
endmodule : eep_link_chk

// ---- serial_eeprom_pin_control_tb_top.sv ----
// bench for the host and eeprom ends joined by one two-wire link
// assumes both ends, the link interface and the checker are compiled
module serial_eeprom_pin_control_tb_top;
   import eep_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int QTR_T = 20;
   localparam int WR_T = 200;
   localparam int LIMIT = 95000;
   logic pclk, presetn, link_clk, por_n, vcc_ok, standby, wr_busy;
   logic psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, st;
   int errors, comparisons, cycles;

   eep_if link_if();
   eep_host #(.QTR(QTR_T)) eep_host_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus(link_if));
   eep_dev #(.FIVE_PIN(1'b0), .WR_CYC(WR_T)) eep_dev_inst (
      .link_clk(link_clk), .por_n(por_n), .vcc_ok(vcc_ok),
      .standby(standby), .wr_busy(wr_busy), .bus(link_if));
   eep_link_chk #(.QTR(QTR_T), .WR_CYC(WR_T)) eep_link_chk_inst (
      .pclk(pclk), .presetn(presetn), .link_clk(link_clk), .por_n(por_n),
      .vcc_ok(vcc_ok), .standby(standby), .wr_busy(wr_busy),
      .scl(link_if.scl), .host_sda_oe(link_if.host_sda_oe),
      .dev_sda_oe(link_if.dev_sda_oe), .wp(link_if.wp));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #32 link_clk = ~link_clk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         end_sim();
      end
   end

   task automatic end_sim;
      if (errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   task automatic check(input string name, input logic [31:0] seen,
         input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // one apb transfer; read data and error taken at the ready edge
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // one link operation, then status polled until idle
   task automatic op(input logic rdo, input logic [1:0] sel,
         input logic [8:0] a, input logic [7:0] d, input logic nk);
      apb(1'b1, OFS_ADDR, {23'h0, a});
      apb(1'b1, OFS_WDATA, {24'h0, d});
      apb(1'b1, OFS_CTRL, {28'h0, sel, rdo, 1'b1});
      st = 32'h1;
      while (st[ST_BUSY] !== 1'b0) begin
         apb(1'b0, OFS_STAT, 32'h0);
         st = rd;
      end
      check("stat", st, {29'h0, nk, 1'b1, 1'b0}); // done set, nack flag as expected
   endtask : op

   task automatic read(input logic [1:0] sel, input logic [8:0] a,
         input logic [7:0] d);
      op(1'b1, sel, a, 8'h00, 1'b0);
      apb(1'b0, OFS_RDATA, 32'h0);
      check("rdata", rd, {24'h0, d}); // byte read back
   endtask : read

   task automatic wait_cycle;
      repeat (6) @(posedge link_clk);
      for (int i = 0; i < 1000 && wr_busy !== 1'b0; i++) begin
         @(posedge link_clk);
      end
      @(posedge pclk);
   endtask : wait_cycle

   initial begin
      presetn = 1'b0;
      por_n = 1'b0;
      vcc_ok = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      link_if.ce_lo = 1'b0;
      link_if.ce_hi = 1'b1;
      link_if.wp = 1'b0;
      errors = 0;
      comparisons = 0;
      cycles = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_CTRL, 32'h0);
      check("ctrl", rd, 32'h0); // control word at reset
      apb(1'b0, 8'h14, 32'h0);
      check("slverr", {31'h0, err}, 32'h1); // unmapped word refused
      op(1'b0, 2'b10, 9'h000, 8'h00, 1'b1); // ignored before power
      por_n <= 1'b1;
      vcc_ok <= 1'b1;
      repeat (6) @(posedge link_clk);
      check("standby", {31'h0, standby}, 32'h1); // standby at start
      op(1'b0, 2'b10, 9'h1a5, 8'h5a, 1'b0); // matching select
      op(1'b0, 2'b10, 9'h0a5, 8'h3c, 1'b1); // busy device silent
      wait_cycle();
      check("standby", {31'h0, standby}, 32'h1); // back in standby
      op(1'b0, 2'b10, 9'h0a5, 8'h3c, 1'b0); // ack after cycle
      wait_cycle();
      read(2'b10, 9'h1a5, 8'h5a); // upper half kept apart
      read(2'b10, 9'h0a5, 8'h3c); // read direction
      link_if.wp <= 1'b1;
      op(1'b0, 2'b10, 9'h1a5, 8'hff, 1'b1); // data byte refused
      wait_cycle();
      read(2'b10, 9'h1a5, 8'h5a); // protected byte unchanged
      link_if.wp <= 1'b0;
      op(1'b0, 2'b10, 9'h1a5, 8'h77, 1'b0); // protect re-read
      wait_cycle();
      read(2'b10, 9'h1a5, 8'h77); // write allowed when low
      for (int s = 0; s < 4; s++) begin
         logic [1:0] sv;
         sv = 2'(s);
         link_if.ce_lo <= sv[0];
         link_if.ce_hi <= sv[1];
         repeat (4) @(posedge link_clk);
         op(1'b0, sv ^ 2'b01, {7'h08, sv}, 8'h11, 1'b1); // low differs
         op(1'b0, sv ^ 2'b10, {7'h08, sv}, 8'h22, 1'b1); // high differs
         op(1'b0, sv, {7'h08, sv}, {6'h0, sv}, 1'b0); // new straps
         wait_cycle();
      end
      read(2'b11, 9'h022, 8'h02); // strapped select pattern
      link_if.ce_lo <= 1'b0;
      link_if.ce_hi <= 1'b1;
      vcc_ok <= 1'b0;
      repeat (8) @(posedge link_clk);
      op(1'b0, 2'b10, 9'h000, 8'h00, 1'b1); // silent on low supply
      vcc_ok <= 1'b1;
      repeat (6) @(posedge link_clk);
      read(2'b10, 9'h0a5, 8'h3c); // responds again
      end_sim();
   end
endmodule : serial_eeprom_pin_control_tb_top
